/* File: uce_pkg.sv */
// constants and types shared by the serial control block
package uce_pkg;

	// ===========================================
	// register map (byte addresses)
	localparam logic [3:0] ADDR_CTRL_TWO = 4'h0;
	localparam logic [3:0] ADDR_LINE_CFG = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;

	// ===========================================
	// serial_control_two field positions
	localparam int BIT_TX_EMPTY_IRQ_EN = 7;
	localparam int BIT_TX_DONE_IRQ_EN = 6;
	localparam int BIT_RX_FULL_IRQ_EN = 5;
	localparam int BIT_LINE_QUIET_IRQ_EN = 4;
	localparam int BIT_TX_ENABLE = 3;
	localparam int BIT_RX_ENABLE = 2;
	localparam int BIT_RX_STANDBY = 1;
	localparam int BIT_BREAK_REQUEST = 0;

	// ===========================================
	// line configuration field positions
	localparam int CFG_LOOPBACK_SEL = 0;
	localparam int CFG_RX_SOURCE_SEL = 1;
	localparam int CFG_SINGLE_LINE_DIRECTION = 2;
	localparam int CFG_NINE_BIT = 3;
	localparam int CFG_WAKE_SEL = 4;

	// ===========================================
	// reset values and codes
	localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
	localparam logic [4:0] LINE_CFG_RESET = 5'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ===========================================
	// character lengths in bit times and default clock cycles per bit time
	localparam logic [3:0] CHAR_BITS_EIGHT = 4'hA;
	localparam logic [3:0] CHAR_BITS_NINE = 4'hB;
	localparam int DEFAULT_BIT_CYCLES = 16;

	typedef enum logic [1:0]
	{
		SEQ_IDLE = 2'b00,
		SEQ_DATA = 2'b01,
		SEQ_PREAMBLE = 2'b10,
		SEQ_BREAK = 2'b11
	} uce_seq_t;

	typedef struct packed
	{
		logic [7:0] ctrl;
		logic [4:0] cfg;
		logic idle_pending;
		logic break_pending;
		logic baud_run;
		uce_seq_t kind;
		logic start;
		logic [3:0] len;
		logic take;
		logic txd;
		logic txd_oe_n;
		logic rxd_owned;
		logic rx_line;
		logic irq;
		logic aw_have;
		logic w_have;
		logic [3:0] waddr;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} uce_state_t;

endpackage

/* File: uce_char_timer.sv */
// character length timer for queued characters
`timescale 1ns/1ps

module uce_char_timer #(
	parameter int BIT_CYCLES = uce_pkg::DEFAULT_BIT_CYCLES,
	parameter int CNT_W = 12
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic [3:0] len_bits,
	output logic busy,
	output logic done
);

	if (CNT_W < 5 || BIT_CYCLES < 1 || (11 * BIT_CYCLES) >= (2 ** CNT_W))
	begin : g_bad_size
		$error("uce_char_timer: BIT_CYCLES does not fit CNT_W");
	end

	localparam logic [CNT_W-1:0] BIT_CYC = CNT_W'(BIT_CYCLES);

	typedef struct packed
	{
		logic busy;
		logic done;
		logic [CNT_W-1:0] cnt;
	} uce_timer_state_t;

	uce_timer_state_t state_reg;
	uce_timer_state_t state_next;

	// ===========================================
	// countdown
	always_comb
	begin
		state_next = state_reg;
		state_next.done = 1'b0;
		if (start && !state_reg.busy)
		begin
			state_next.busy = 1'b1;
			// start and done hand-offs add three cycles to the character
			state_next.cnt = CNT_W'({{(CNT_W-4){1'b0}}, len_bits} * BIT_CYC - CNT_W'(3));
		end
		else if (state_reg.busy)
		begin
			if (state_reg.cnt == '0)
			begin
				state_next.busy = 1'b0;
				state_next.done = 1'b1;
			end
			else
				state_next.cnt = state_reg.cnt - 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign busy = state_reg.busy;
	assign done = state_reg.done;

endmodule

/* File: uce_control.sv */
// control register, pin ownership and queued character sequencing
`timescale 1ns/1ps

// Function
// [R1] bit 7 lets a set transmit-buffer-empty flag raise the interrupt request
// [R2] bit 6 inverted: 0 lets transmit-done raise the request, 1 blocks it
// [R3] bit 5 lets a set receive-buffer-full flag raise the request
// [R4] bit 4 lets a set line-quiet flag raise the request
// [R5] bit 3 turns the transmitter on and gives it the serial output pin
// [R6] internal loopback releases the output pin even with transmitter enabled
// [R7] single-wire mode: direction bit decides whether the shared pin transmits
// [R8] transmit enable written 0 then 1 while busy queues one idle character
// [R9] after disable the pin stays driven until queued characters finish
// [R10] bit 2 turns the receiver on; off releases the serial input pin
// [R11] writing 1 to bit 1 puts the receiver in wakeup standby
// [R12] wakeup is idle line with select 0, address mark with select 1
// [R13] the detected wakeup condition clears standby in hardware
// [R14] writing break request 1 then 0 queues one break character
// [R15] further break characters keep being queued while break request stays 1
// [R16] a second break may be queued before software clears the request
// [R17] the control register is readable and writable at any time
// [R18] baud generator stays off until receiver or transmitter is first enabled
// [R19] transmit enable rising queues a preamble, which clears transmit-done
// [R20] break length is 10 bit times in 8-bit mode, 11 in 9-bit mode
module uce_control #(
	parameter int BIT_CYCLES = uce_pkg::DEFAULT_BIT_CYCLES
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_buffer_empty_flag,
	input wire logic rx_buffer_full_flag,
	input wire logic line_quiet_flag,
	input wire logic tx_data_bit,
	input wire logic rx_line_idle_seen,
	input wire logic rx_addr_mark_seen,
	input wire logic rxd_in,
	input wire logic txd_in,
	output logic txd_out,
	output logic txd_oe_n,
	output logic rxd_owned,
	output logic rx_serial,
	output logic tx_char_take,
	output logic tx_enable_bit,
	output logic rx_enable_bit,
	output logic rx_standby,
	output logic baud_enable,
	output logic irq_request
);

	uce_pkg::uce_state_t state_reg;
	uce_pkg::uce_state_t state_next;
	logic timer_busy;
	logic timer_done;
	logic tx_done_flag;

	// ===========================================
	// parameter check
	if (BIT_CYCLES < 1 || (11 * BIT_CYCLES) >= 4096)
	begin : g_bad_bit_cycles
		$error("uce_control: BIT_CYCLES too large for the character timer");
	end

	uce_char_timer #(
		.BIT_CYCLES(BIT_CYCLES),
		.CNT_W(12)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(state_reg.start),
		.len_bits(state_reg.len),
		.busy(timer_busy),
		.done(timer_done)
	);

	// ===========================================
	// next state
	always_comb
	begin
		logic [7:0] c;
		logic [4:0] f;
		logic wr_ctrl;
		logic wr_cfg;
		logic wr_ok;
		logic owned;
		logic busy_any;
		logic [3:0] ch_len;
		c = state_reg.ctrl;
		f = state_reg.cfg;
		wr_ctrl = 1'b0;
		wr_cfg = 1'b0;
		wr_ok = 1'b0;
		owned = 1'b0;
		busy_any = 1'b0;
		ch_len = uce_pkg::CHAR_BITS_EIGHT;
		state_next = state_reg;
		state_next.start = 1'b0;
		state_next.take = 1'b0;

		// write channel: address and data in either order
		if (s_axi_awvalid && state_reg.awready)
		begin
			state_next.aw_have = 1'b1;
			state_next.waddr = s_axi_awaddr;
			state_next.awready = 1'b0;
		end
		if (s_axi_wvalid && state_reg.wready)
		begin
			state_next.w_have = 1'b1;
			state_next.wdata = s_axi_wdata[7:0];
			state_next.wstrb0 = s_axi_wstrb[0];
			state_next.wready = 1'b0;
		end
		if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid)
		begin
			wr_ok = (state_reg.waddr == uce_pkg::ADDR_CTRL_TWO) || (state_reg.waddr == uce_pkg::ADDR_LINE_CFG)
				|| (state_reg.waddr == uce_pkg::ADDR_STATUS);
			wr_ctrl = state_reg.wstrb0 && (state_reg.waddr == uce_pkg::ADDR_CTRL_TWO); // [R17]
			wr_cfg = state_reg.wstrb0 && (state_reg.waddr == uce_pkg::ADDR_LINE_CFG);
			state_next.bvalid = 1'b1;
			state_next.bresp = wr_ok ? uce_pkg::RESP_OKAY : uce_pkg::RESP_SLVERR;
			state_next.aw_have = 1'b0;
			state_next.w_have = 1'b0;
		end
		if (state_reg.bvalid && s_axi_bready)
		begin
			state_next.bvalid = 1'b0;
			state_next.awready = 1'b1;
			state_next.wready = 1'b1;
		end

		// control register update and its side effects
		if (wr_cfg)
			f = state_reg.wdata[4:0];
		if (wr_ctrl)
		begin
			c = state_reg.wdata;
			if (c[uce_pkg::BIT_TX_ENABLE] && !state_reg.ctrl[uce_pkg::BIT_TX_ENABLE])
				state_next.idle_pending = 1'b1; // [R8] [R19]
			if (c[uce_pkg::BIT_BREAK_REQUEST] && !state_reg.ctrl[uce_pkg::BIT_BREAK_REQUEST])
				state_next.break_pending = 1'b1; // [R14]
			if (c[uce_pkg::BIT_TX_ENABLE] || c[uce_pkg::BIT_RX_ENABLE])
				state_next.baud_run = 1'b1; // [R18]
		end
		else if (state_reg.ctrl[uce_pkg::BIT_RX_STANDBY])
		begin
			if (f[uce_pkg::CFG_WAKE_SEL] ? rx_addr_mark_seen : rx_line_idle_seen) // [R12]
				c[uce_pkg::BIT_RX_STANDBY] = 1'b0; // [R13]
		end
		state_next.ctrl = c; // [R11]
		state_next.cfg = f;

		// character sequencer
		ch_len = f[uce_pkg::CFG_NINE_BIT] ? uce_pkg::CHAR_BITS_NINE : uce_pkg::CHAR_BITS_EIGHT; // [R20]
		if (timer_done)
			state_next.kind = uce_pkg::SEQ_IDLE;
		else if (state_reg.kind == uce_pkg::SEQ_IDLE && !timer_busy && state_reg.baud_run)
		begin
			if (state_reg.break_pending || state_reg.ctrl[uce_pkg::BIT_BREAK_REQUEST])
			begin
				state_next.kind = uce_pkg::SEQ_BREAK; // [R15] [R16]
				// a new request written in the same cycle as the start wins
				state_next.break_pending = wr_ctrl && c[uce_pkg::BIT_BREAK_REQUEST]
					&& !state_reg.ctrl[uce_pkg::BIT_BREAK_REQUEST]; // [R16]
				state_next.start = 1'b1;
			end
			else if (state_reg.idle_pending)
			begin
				state_next.kind = uce_pkg::SEQ_PREAMBLE; // [R8]
				state_next.idle_pending = wr_ctrl && c[uce_pkg::BIT_TX_ENABLE]
					&& !state_reg.ctrl[uce_pkg::BIT_TX_ENABLE];
				state_next.start = 1'b1;
			end
			else if (state_reg.ctrl[uce_pkg::BIT_TX_ENABLE] && !tx_buffer_empty_flag)
			begin
				state_next.kind = uce_pkg::SEQ_DATA; // [R5]
				state_next.take = 1'b1;
				state_next.start = 1'b1;
			end
		end
		state_next.len = ch_len;

		// pin ownership and line levels
		busy_any = (state_reg.kind != uce_pkg::SEQ_IDLE) || state_reg.idle_pending || state_reg.break_pending
			|| state_reg.ctrl[uce_pkg::BIT_BREAK_REQUEST];
		owned = state_reg.ctrl[uce_pkg::BIT_TX_ENABLE] || busy_any; // [R5] [R9]
		if (f[uce_pkg::CFG_LOOPBACK_SEL] && !f[uce_pkg::CFG_RX_SOURCE_SEL])
			owned = 1'b0; // [R6]
		else if (f[uce_pkg::CFG_LOOPBACK_SEL] && f[uce_pkg::CFG_RX_SOURCE_SEL])
			owned = owned && f[uce_pkg::CFG_SINGLE_LINE_DIRECTION]; // [R7]
		state_next.txd_oe_n = !owned;
		unique case (state_reg.kind)
			uce_pkg::SEQ_IDLE: state_next.txd = 1'b1;
			uce_pkg::SEQ_DATA: state_next.txd = tx_data_bit;
			uce_pkg::SEQ_PREAMBLE: state_next.txd = 1'b1;
			uce_pkg::SEQ_BREAK: state_next.txd = 1'b0; // [R15]
		endcase
		state_next.rxd_owned = c[uce_pkg::BIT_RX_ENABLE] && !f[uce_pkg::CFG_LOOPBACK_SEL]; // [R10]
		if (!f[uce_pkg::CFG_LOOPBACK_SEL])
			state_next.rx_line = rxd_in;
		else if (f[uce_pkg::CFG_RX_SOURCE_SEL])
			state_next.rx_line = txd_in; // [R7]
		else
			state_next.rx_line = state_reg.txd; // [R6]

		// interrupt request gating
		state_next.irq = (c[uce_pkg::BIT_TX_EMPTY_IRQ_EN] && tx_buffer_empty_flag) // [R1]
			|| (!c[uce_pkg::BIT_TX_DONE_IRQ_EN] && tx_done_flag) // [R2]
			|| (c[uce_pkg::BIT_RX_FULL_IRQ_EN] && rx_buffer_full_flag) // [R3]
			|| (c[uce_pkg::BIT_LINE_QUIET_IRQ_EN] && line_quiet_flag); // [R4]

		// read channel
		if (s_axi_arvalid && state_reg.arready)
		begin
			state_next.arready = 1'b0;
			state_next.rvalid = 1'b1;
			state_next.rresp = uce_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				uce_pkg::ADDR_CTRL_TWO: state_next.rdata = {24'h000000, state_reg.ctrl}; // [R17]
				uce_pkg::ADDR_LINE_CFG: state_next.rdata = {27'h0000000, state_reg.cfg};
				uce_pkg::ADDR_STATUS: state_next.rdata = {24'h000000, state_reg.rxd_owned, !state_reg.txd_oe_n,
					state_reg.baud_run, busy_any, line_quiet_flag, rx_buffer_full_flag, tx_done_flag,
					tx_buffer_empty_flag};
				default:
				begin
					state_next.rdata = 32'h00000000;
					state_next.rresp = uce_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (state_reg.rvalid && s_axi_rready)
		begin
			state_next.rvalid = 1'b0;
			state_next.arready = 1'b1;
		end
	end

	// transmit-done: buffer empty, sequencer idle, timer stopped, no idle or break pending
	assign tx_done_flag = tx_buffer_empty_flag && (state_reg.kind == uce_pkg::SEQ_IDLE) && !timer_busy
		&& !state_reg.idle_pending && !state_reg.break_pending; // [R19]

	// ===========================================
	// state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= '0;
			state_reg.ctrl <= uce_pkg::CTRL_TWO_RESET;
			state_reg.cfg <= uce_pkg::LINE_CFG_RESET;
			state_reg.kind <= uce_pkg::SEQ_IDLE;
			state_reg.len <= uce_pkg::CHAR_BITS_EIGHT;
			state_reg.txd <= 1'b1;
			state_reg.txd_oe_n <= 1'b1;
			state_reg.rx_line <= 1'b1;
			state_reg.awready <= 1'b1;
			state_reg.wready <= 1'b1;
			state_reg.arready <= 1'b1;
		end
		else
			state_reg <= state_next;
	end

	// ===========================================
	// outputs
	assign s_axi_awready = state_reg.awready;
	assign s_axi_wready = state_reg.wready;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_arready = state_reg.arready;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rresp = state_reg.rresp;
	assign s_axi_rdata = state_reg.rdata;
	assign txd_out = state_reg.txd;
	assign txd_oe_n = state_reg.txd_oe_n;
	assign rxd_owned = state_reg.rxd_owned;
	assign rx_serial = state_reg.rx_line;
	assign tx_char_take = state_reg.take;
	assign tx_enable_bit = state_reg.ctrl[uce_pkg::BIT_TX_ENABLE];
	assign rx_enable_bit = state_reg.ctrl[uce_pkg::BIT_RX_ENABLE];
	assign rx_standby = state_reg.ctrl[uce_pkg::BIT_RX_STANDBY];
	assign baud_enable = state_reg.baud_run;
	assign irq_request = state_reg.irq;

endmodule

/* File: uce_control_monitor.sv */
// assertions for the serial control block
`timescale 1ns/1ps
module uce_control_monitor(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic rx_line_idle_seen,
	input wire logic rx_addr_mark_seen,
	input wire logic tx_char_take,
	input wire logic tx_enable_bit,
	input wire logic rx_enable_bit,
	input wire logic rxd_owned,
	input wire logic rx_standby,
	input wire logic baud_enable
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ===========================================
	// register bus answers
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	property p_wr_answer;
		s_wr_taken |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	// ===========================================
	// baud generator
	property p_baud_rise;
		$rose(baud_enable) |-> tx_enable_bit || rx_enable_bit;
	endproperty
	a_baud_rise: assert property (p_baud_rise) else $error("baud on without enable");
	property p_baud_hold;
		baud_enable |=> baud_enable;
	endproperty
	a_baud_hold: assert property (p_baud_hold) else $error("baud dropped");
	// ===========================================
	// pins, standby and characters
	property p_rx_pin;
		!rx_enable_bit [*2] |-> !rxd_owned;
	endproperty
	a_rx_pin: assert property (p_rx_pin) else $error("rx pin kept while off");
	property p_standby_rise;
		$rose(rx_standby) |-> $rose(s_axi_bvalid);
	endproperty
	a_standby_rise: assert property (p_standby_rise) else $error("standby without write");
	sequence s_wake;
		$past(rx_line_idle_seen) || $past(rx_addr_mark_seen);
	endsequence
	property p_standby_fall;
		$fell(rx_standby) |-> s_wake or $rose(s_axi_bvalid);
	endproperty
	a_standby_fall: assert property (p_standby_fall) else $error("standby cleared alone");
	property p_take_gap;
		tx_char_take |=> !tx_char_take [*8];
	endproperty
	a_take_gap: assert property (p_take_gap) else $error("characters too short");
endmodule

bind uce_control uce_control_monitor u_mon (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.rx_line_idle_seen(rx_line_idle_seen),
	.rx_addr_mark_seen(rx_addr_mark_seen),
	.tx_char_take(tx_char_take),
	.tx_enable_bit(tx_enable_bit),
	.rx_enable_bit(rx_enable_bit),
	.rxd_owned(rxd_owned),
	.rx_standby(rx_standby),
	.baud_enable(baud_enable)
);

/* File: uce_remote_node.sv */
// remote serial node watching the transmit line
`timescale 1ns/1ps
module uce_remote_node(
	input wire logic aclk,
	input wire logic txd_out,
	input wire logic txd_oe_n,
	output logic rxd_in,
	output logic txd_line,
	output int low_len,
	output int brk_cnt
);
	int run = 0;
	// ===========================================
	// line level, pulled up when released
	assign txd_line = txd_oe_n ? 1'b1 : txd_out;
	initial rxd_in = 1'b1;
	initial low_len = 0;
	initial brk_cnt = 0;
	// ===========================================
	// measure each low stretch of the line
	always @(posedge aclk)
	begin
		if (!txd_line)
			run <= run + 1;
		else if (run != 0)
		begin
			low_len <= run;
			brk_cnt <= brk_cnt + 1;
			run <= 0;
		end
	end
endmodule

/* File: testbench.sv */
// testbench for the serial control block
`timescale 1ns/1ps
module testbench;
	localparam int BC = 2;
	logic aclk, aresetn, tx_buffer_empty_flag, rx_buffer_full_flag, line_quiet_flag;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_data_bit;
	logic rx_line_idle_seen, rx_addr_mark_seen, rxd_in, txd_in, txd_out, txd_oe_n, rxd_owned;
	logic rx_serial, tx_char_take, tx_enable_bit, rx_enable_bit, rx_standby, baud_enable, irq_request;
	int bad_count, cmp_count, cycles, low_len, brk_cnt;
	uce_control #(
		.BIT_CYCLES(BC)
	) u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.tx_buffer_empty_flag(tx_buffer_empty_flag), .rx_buffer_full_flag(rx_buffer_full_flag),
		.line_quiet_flag(line_quiet_flag), .tx_data_bit(tx_data_bit), .rx_line_idle_seen(rx_line_idle_seen),
		.rx_addr_mark_seen(rx_addr_mark_seen), .rxd_in(rxd_in), .txd_in(txd_in), .txd_out(txd_out),
		.txd_oe_n(txd_oe_n), .rxd_owned(rxd_owned), .rx_serial(rx_serial), .tx_char_take(tx_char_take),
		.tx_enable_bit(tx_enable_bit), .rx_enable_bit(rx_enable_bit), .rx_standby(rx_standby),
		.baud_enable(baud_enable), .irq_request(irq_request)
	);
	uce_remote_node u_node (.aclk(aclk), .txd_out(txd_out), .txd_oe_n(txd_oe_n), .rxd_in(rxd_in),
		.txd_line(txd_in), .low_len(low_len), .brk_cnt(brk_cnt));
	always #4 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			summarize();
		end
	end
	// ===========================================
	// shared tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic aw, w;
		aw = 0;
		w = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge aclk);
			if (!aw && s_axi_awready === 1'b1)
			begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1)
			begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do
			@(posedge aclk);
		while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rdr(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge aclk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic pulse(input logic idle);
		if (idle)
			rx_line_idle_seen <= 1'b1;
		else
			rx_addr_mark_seen <= 1'b1;
		@(posedge aclk);
		rx_line_idle_seen <= 1'b0;
		rx_addr_mark_seen <= 1'b0;
		cyc(1);
	endtask
	// ===========================================
	// scenarios
	task automatic t_reset();
		check("baud", 0, baud_enable);
		rdr(uce_pkg::ADDR_CTRL_TWO);
		check("ctrl", uce_pkg::CTRL_TWO_RESET, rd);
		rdr(4'hC);
		check("resp", uce_pkg::RESP_SLVERR, resp);
		wr(4'hC, 8'h00);
		check("bresp", uce_pkg::RESP_SLVERR, resp);
		wr(uce_pkg::ADDR_STATUS, 8'hFF);
		check("bresp ok", uce_pkg::RESP_OKAY, resp);
	endtask
	task automatic t_irq();
		logic [7:0] ctl [6] = '{8'hC0, 8'h40, 8'h00, 8'h60, 8'h40, 8'h50};
		logic [2:0] flg [6] = '{3'h4, 3'h4, 3'h4, 3'h2, 3'h2, 3'h1};
		logic exp [6] = '{1, 0, 1, 1, 0, 1};
		for (int i = 0; i < 6; i++)
		begin
			wr(4'h0, ctl[i]);
			{tx_buffer_empty_flag, rx_buffer_full_flag, line_quiet_flag} <= flg[i];
			cyc(3);
			check("irq", exp[i], irq_request);
		end
		{tx_buffer_empty_flag, rx_buffer_full_flag, line_quiet_flag} <= 3'h4;
	endtask
	task automatic t_pins();
		logic [7:0] cfg [4] = '{8'h00, 8'h01, 8'h03, 8'h07};
		logic oe [4] = '{0, 1, 1, 0};
		check("baud off", 0, baud_enable);
		wr(4'h0, 8'h48);
		check("baud on", 1, baud_enable);
		check("tx en", 1, tx_enable_bit);
		for (int i = 0; i < 4; i++)
		begin
			wr(4'h4, cfg[i]);
			cyc(2);
			check("oe_n", oe[i], txd_oe_n);
		end
		wr(4'h4, 8'h00);
	endtask
	task automatic t_break(input logic [7:0] cfg, input int bits);
		int n0;
		wr(4'h4, cfg);
		n0 = brk_cnt;
		wr(4'h0, 8'h49);
		wr(4'h0, 8'h48);
		check("break line", 0, txd_out);
		check("rx source", 1, rx_serial);
		for (int i = 0; i < 100 && brk_cnt == n0; i++)
			cyc(1);
		check("break", bits * BC, low_len);
	endtask
	task automatic t_standby();
		for (int s = 0; s < 2; s++)
		begin
			wr(4'h4, s ? 8'h10 : 8'h00);
			wr(4'h0, 8'h4E);
			check("standby", 1, rx_standby);
			check("rx pin", 1, rxd_owned);
			check("rx en", 1, rx_enable_bit);
			pulse(s);
			check("no wake", 1, rx_standby);
			pulse(!s);
			check("wake", 0, rx_standby);
		end
		wr(4'h0, 8'h48);
		cyc(2);
		check("rx free", 0, rxd_owned);
	endtask
	task automatic t_disable();
		int t0;
		tx_buffer_empty_flag <= 1'b0;
		for (int i = 0; i < 100 && tx_char_take !== 1'b1; i++)
			cyc(1);
		check("take", 1, tx_char_take);
		tx_buffer_empty_flag <= 1'b1;
		t0 = cycles;
		wr(4'h0, 8'h40);
		wr(4'h0, 8'h48);
		wr(4'h0, 8'h40);
		while (txd_oe_n !== 1'b1 && cycles - t0 < 100)
			cyc(1);
		check("held", 1, cycles - t0 >= 20 * BC);
		check("freed", 1, txd_oe_n);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		aclk = 0;
		aresetn = 0;
		bad_count = 0;
		cmp_count = 0;
		cycles = 0;
		s_axi_awaddr = 4'h0;
		s_axi_araddr = 4'h0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{tx_buffer_empty_flag, rx_buffer_full_flag, line_quiet_flag, tx_data_bit} = 4'h9;
		{rx_line_idle_seen, rx_addr_mark_seen} = 2'h0;
		cyc(2);
		aresetn <= 1'b1;
		cyc(1);
		t_reset();
		t_irq();
		t_pins();
		t_break(8'h00, 10);
		t_break(8'h08, 11);
		t_standby();
		t_disable();
		summarize();
	end
endmodule
